// ---- udt_consts.vh ----
/*
  Constants for the up/down encoder timer: prescaler, phase modes,
  clear-source codes, edge-select codes.
  Assumes inclusion by bare name from the timer design file.
*/
`ifndef UDT_CONSTS_VH
`define UDT_CONSTS_VH

`define UDT_WIDTH 16
`define UDT_MAX 16'hffff
`define UDT_ZERO 16'h0000
`define UDT_ONE 16'h0001
`define UDT_PRESC_W 9
`define UDT_PRESC_MIN_SHIFT 4'h3
`define UDT_PHASE_M1 3'h4
`define UDT_PHASE_M2 3'h5
`define UDT_PHASE_M3 3'h6
`define UDT_PHASE_M4 3'h7
`define UDT_EDGE_RISE 2'h1
`define UDT_EDGE_FALL 2'h2
`define UDT_EDGE_BOTH 2'h3
`define UDT_CLR_EXT 2'h1
`define UDT_CLR_CMP 2'h2
`define UDT_CLR_BOTH 2'h3

`endif

// ---- udt_timer.v ----
/*
  Up/down encoder timer: 16-bit counter, two compare and two
  capture/compare channels, general timer and encoder modes.
  Assumes static configuration ports from software and asynchronous
  pins for count, clear and trigger inputs.
*/
// Operation
// - Interval mode compares counter with cycle compare
// - After match counter loads zero, then one
// - Free-run wraps at max, sets overflow flag
// - Each compare match raises its own irq; in scheme B the cycle and second irqs come only from the clearing match
// - Capture channel latches counter on trigger edge
// - Capture edge raises capture irq
// - Capture edge rising, falling or both
// - Timer output only in general-purpose mode
// - Count clock main clock divided 8..512
// - Cycle compare sets period, second sets duty
// - Output waveform starts at second period
// - Encoder mode counts only external inputs
// - Mode 1: B high down, low up
// - Mode 2: A edge up, B edge down
// - Mode 2 simultaneous edges: no count
// - Mode 3: B sampled high up, low down
// - Mode 4: count every edge, auto direction
// - Scheme A: selectable clear source, reload option
// - Scheme B up cycle match clears
// - Scheme B down second match clears
// - Overflow and underflow irqs, counting continues
// - Scheme A reload on zero while down
// - Mode 4 simultaneous edges keep direction
`timescale 1ns/1ps
`default_nettype none
`include "udt_consts.vh"

module udt_timer (
  input wire clk_in,
  input wire resetn_in,
  input wire count_enable_bit_in,
  input wire updown_mode_select_in,
  input wire interval_select_in,
  input wire clear_scheme_select_in,
  input wire [1:0] clear_source_in,
  input wire reload_enable_in,
  input wire [2:0] phase_mode_field_in,
  input wire [2:0] prescale_select_in,
  input wire output_level_select_in,
  input wire [1:0] capcmp_mode_in,
  input wire [1:0] edge_select_a_in,
  input wire [1:0] edge_select_b_in,
  input wire [1:0] edge_select_cap0_in,
  input wire [1:0] edge_select_cap1_in,
  input wire [15:0] cycle_compare_in,
  input wire [15:0] second_compare_in,
  input wire [15:0] capcmp_write_0_in,
  input wire [15:0] capcmp_write_1_in,
  input wire count_input_a_in,
  input wire count_input_b_in,
  input wire external_clear_pin_in,
  input wire capture_trigger_0_in,
  input wire capture_trigger_1_in,
  output reg [15:0] encoder_counter_out,
  output reg [15:0] capcmp_channel_0_out,
  output reg [15:0] capcmp_channel_1_out,
  output reg overflow_flag_out,
  output reg count_down_out,
  output reg timer_out_pin_out,
  output reg timer_out_pin_oe_out,
  output reg cycle_match_irq_out,
  output reg second_match_irq_out,
  output reg capcmp_irq_0_out,
  output reg capcmp_irq_1_out,
  output reg overflow_irq_out,
  output reg underflow_irq_out
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  wire [4:0] pin_raw;
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  reg [4:0] prev_r;
  wire [4:0] rise;
  wire [4:0] fall;

  assign pin_raw = {capture_trigger_1_in, capture_trigger_0_in, external_clear_pin_in,
                    count_input_b_in, count_input_a_in};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi] <= sync2_r[gi];
        end
      end
      assign rise[gi] = sync2_r[gi] & ~prev_r[gi];
      assign fall[gi] = ~sync2_r[gi] & prev_r[gi];
    end
  endgenerate

  function edge_ok;
    input [1:0] sel;
    input r;
    input f;
    begin
      edge_ok = ((sel == `UDT_EDGE_RISE) & r) | ((sel == `UDT_EDGE_FALL) & f) |
                ((sel == `UDT_EDGE_BOTH) & (r | f));
    end
  endfunction

  wire a_edge = edge_ok(edge_select_a_in, rise[0], fall[0]);
  wire b_edge = edge_ok(edge_select_b_in, rise[1], fall[1]);
  wire clr_edge = rise[2];
  wire cap0_edge = edge_ok(edge_select_cap0_in, rise[3], fall[3]);
  wire cap1_edge = edge_ok(edge_select_cap1_in, rise[4], fall[4]);
  wire a_any = rise[0] | fall[0];
  wire b_any = rise[1] | fall[1];

  ////////////////////////////////////////////////////////////////////
  // Prescaler
  reg [`UDT_PRESC_W-1:0] presc_r;
  wire [3:0] presc_shift = {1'b0, prescale_select_in} + `UDT_PRESC_MIN_SHIFT;
  wire [`UDT_PRESC_W-1:0] presc_mask =
    (`UDT_PRESC_W'h1 << presc_shift) - `UDT_PRESC_W'h1;
  wire int_tick = count_enable_bit_in & ((presc_r & presc_mask) == presc_mask);

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      presc_r <= {`UDT_PRESC_W{1'b0}};
    else if (!count_enable_bit_in)
      presc_r <= {`UDT_PRESC_W{1'b0}};
    else
      presc_r <= presc_r + `UDT_PRESC_W'h1;
  end

  ////////////////////////////////////////////////////////////////////
  // Count event and direction
  reg tick;
  reg dir_down;
  reg dir_last_r;

  always @* begin
    tick = 1'b0;
    dir_down = dir_last_r;
    if (!updown_mode_select_in) begin
      tick = int_tick;
      dir_down = 1'b0;
    end else if (count_enable_bit_in) begin
      case (phase_mode_field_in)
        `UDT_PHASE_M1: begin
          tick = a_edge;
          dir_down = sync2_r[1];
        end
        `UDT_PHASE_M2: begin
          tick = a_edge ^ b_edge;
          dir_down = b_edge;
        end
        `UDT_PHASE_M3: begin
          tick = a_edge;
          dir_down = ~sync2_r[1];
        end
        `UDT_PHASE_M4: begin
          tick = a_any | b_any;
          if (a_any & b_any)
            dir_down = dir_last_r;
          else if (a_any)
            dir_down = (sync2_r[0] == sync2_r[1]);
          else
            dir_down = (sync2_r[0] != sync2_r[1]);
        end
        default: begin
          tick = 1'b0;
          dir_down = dir_last_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Compare matches, held until the next count clock
  wire m_cyc = (encoder_counter_out == cycle_compare_in);
  wire m_sec = (encoder_counter_out == second_compare_in);
  wire m_cc0 = capcmp_mode_in[0] & (encoder_counter_out == capcmp_channel_0_out);
  wire m_cc1 = capcmp_mode_in[1] & (encoder_counter_out == capcmp_channel_1_out);
  wire at_max = (encoder_counter_out == `UDT_MAX);
  wire at_zero = (encoder_counter_out == `UDT_ZERO);
  wire scheme_a = updown_mode_select_in & ~clear_scheme_select_in;
  wire scheme_b = updown_mode_select_in & clear_scheme_select_in;

  reg [15:0] cnt_nxt;
  reg cyc_irq;
  reg sec_irq;
  reg ext_clr;

  always @* begin
    cnt_nxt = encoder_counter_out;
    cyc_irq = 1'b0;
    sec_irq = 1'b0;
    ext_clr = 1'b0;
    if (scheme_a & clear_source_in[0] & clr_edge & count_enable_bit_in) begin
      ext_clr = 1'b1;
      cnt_nxt = `UDT_ZERO;
    end else if (tick) begin
      cnt_nxt = dir_down ? encoder_counter_out - `UDT_ONE : encoder_counter_out + `UDT_ONE;
      if (!updown_mode_select_in) begin
        cyc_irq = m_cyc;
        if (interval_select_in & m_cyc)
          cnt_nxt = `UDT_ZERO;
        sec_irq = m_sec;
      end else if (scheme_b) begin
        if (!dir_down & m_cyc) begin
          cnt_nxt = `UDT_ZERO;
          cyc_irq = 1'b1;
        end
        if (dir_down & m_sec) begin
          cnt_nxt = `UDT_ZERO;
          sec_irq = 1'b1;
        end
      end else begin
        cyc_irq = m_cyc;
        sec_irq = m_sec;
        if (clear_source_in[1] & m_cyc & !dir_down)
          cnt_nxt = `UDT_ZERO;
        if (reload_enable_in & dir_down & at_zero)
          cnt_nxt = cycle_compare_in;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Counter, capture, flags and irq pulses
  wire cap0_fire = ~capcmp_mode_in[0] & cap0_edge & count_enable_bit_in;
  wire cap1_fire = ~capcmp_mode_in[1] & cap1_edge & count_enable_bit_in;
  reg [1:0] period_cnt_r;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      encoder_counter_out <= `UDT_ZERO;
      capcmp_channel_0_out <= `UDT_ZERO;
      capcmp_channel_1_out <= `UDT_ZERO;
      overflow_flag_out <= 1'b0;
      count_down_out <= 1'b0;
      dir_last_r <= 1'b0;
      cycle_match_irq_out <= 1'b0;
      second_match_irq_out <= 1'b0;
      capcmp_irq_0_out <= 1'b0;
      capcmp_irq_1_out <= 1'b0;
      overflow_irq_out <= 1'b0;
      underflow_irq_out <= 1'b0;
      period_cnt_r <= 2'h0;
      timer_out_pin_out <= 1'b0;
      timer_out_pin_oe_out <= 1'b0;
    end else begin
      encoder_counter_out <= cnt_nxt;
      if (tick) begin
        dir_last_r <= dir_down;
        count_down_out <= dir_down;
      end
      if (tick & !dir_down & at_max & !ext_clr)
        overflow_flag_out <= 1'b1;
      else if (!count_enable_bit_in)
        overflow_flag_out <= 1'b0;
      cycle_match_irq_out <= cyc_irq;
      second_match_irq_out <= sec_irq;
      overflow_irq_out <= tick & !ext_clr & !dir_down & at_max;
      underflow_irq_out <= tick & !ext_clr & dir_down & at_zero;
      if (cap0_fire)
        capcmp_channel_0_out <= encoder_counter_out;
      else if (capcmp_mode_in[0] & !count_enable_bit_in)
        capcmp_channel_0_out <= capcmp_write_0_in;
      if (cap1_fire)
        capcmp_channel_1_out <= encoder_counter_out;
      else if (capcmp_mode_in[1] & !count_enable_bit_in)
        capcmp_channel_1_out <= capcmp_write_1_in;
      capcmp_irq_0_out <= cap0_fire | (tick & m_cc0);
      capcmp_irq_1_out <= cap1_fire | (tick & m_cc1);
      if (!count_enable_bit_in)
        period_cnt_r <= 2'h0;
      else if (tick & m_cyc & interval_select_in & (period_cnt_r != 2'h2))
        period_cnt_r <= period_cnt_r + 2'h1;
      timer_out_pin_oe_out <= ~updown_mode_select_in;
      if (period_cnt_r == 2'h0)
        timer_out_pin_out <= output_level_select_in;
      else if (tick & m_cyc)
        timer_out_pin_out <= ~output_level_select_in;
      else if (tick & m_sec)
        timer_out_pin_out <= output_level_select_in;
    end
  end

endmodule
`default_nettype wire

// ---- udt_monitor.sv ----
/* Port checker for the up/down encoder timer.
   Sees only top ports; bound to udt_timer below. */
`timescale 1ns/1ps
`default_nettype none
module udt_monitor (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic updown_mode_select_in,
  input wire logic interval_select_in,
  input wire logic clear_scheme_select_in,
  input wire logic reload_enable_in,
  input wire logic [1:0] capcmp_mode_in,
  input wire logic [15:0] cycle_compare_in,
  input wire logic [15:0] encoder_counter_out,
  input wire logic [15:0] capcmp_channel_0_out,
  input wire logic timer_out_pin_oe_out,
  input wire logic cycle_match_irq_out,
  input wire logic second_match_irq_out,
  input wire logic capcmp_irq_0_out,
  input wire logic capcmp_irq_1_out,
  input wire logic overflow_irq_out,
  input wire logic underflow_irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  wire [5:0] irq_w = {cycle_match_irq_out, second_match_irq_out, capcmp_irq_0_out,
    capcmp_irq_1_out, overflow_irq_out, underflow_irq_out};
  property p_pulse;
    |irq_w |=> (irq_w & $past(irq_w)) == 6'h00;
  endproperty
  a_pulse: assert property (p_pulse) else $error("irq too long");
  property p_match;
    cycle_match_irq_out && !updown_mode_select_in |->
      $past(encoder_counter_out) == cycle_compare_in;
  endproperty
  a_match: assert property (p_match) else $error("match off");
  property p_intv;
    cycle_match_irq_out && !updown_mode_select_in && interval_select_in |->
      encoder_counter_out == 16'h0000;
  endproperty
  a_intv: assert property (p_intv) else $error("no clear");
  property p_oe;
    1'h1 |=> timer_out_pin_oe_out == !$past(updown_mode_select_in);
  endproperty
  a_oe: assert property (p_oe) else $error("oe wrong");
  property p_cap;
    $changed(capcmp_channel_0_out) && !capcmp_mode_in[0] |-> capcmp_irq_0_out;
  endproperty
  a_cap: assert property (p_cap) else $error("capture no irq");
  property p_schb;
    (cycle_match_irq_out || second_match_irq_out) && updown_mode_select_in &&
      clear_scheme_select_in |-> encoder_counter_out == 16'h0000;
  endproperty
  a_schb: assert property (p_schb) else $error("no clear");
  property p_ovf;
    overflow_irq_out |-> encoder_counter_out == 16'h0000;
  endproperty
  a_ovf: assert property (p_ovf) else $error("ovf value");
  property p_udf;
    underflow_irq_out |-> encoder_counter_out ==
      (reload_enable_in && !clear_scheme_select_in ? cycle_compare_in : 16'hffff);
  endproperty
  a_udf: assert property (p_udf) else $error("udf value");
endmodule
bind udt_timer udt_monitor i_mon (.clk_in, .resetn_in, .updown_mode_select_in,
  .interval_select_in, .clear_scheme_select_in, .reload_enable_in, .capcmp_mode_in,
  .cycle_compare_in, .encoder_counter_out, .capcmp_channel_0_out, .timer_out_pin_oe_out,
  .cycle_match_irq_out, .second_match_irq_out, .capcmp_irq_0_out, .capcmp_irq_1_out,
  .overflow_irq_out, .underflow_irq_out);
`default_nettype wire

// ---- udt_enc_model.sv ----
/* Encoder stand-in: two quadrature lines.
   Stepped by the bench; lines move on the rising clock. */
`timescale 1ns/1ps
`default_nettype none
module udt_enc_model (
  input wire logic clk_in,
  input wire logic move_in,
  input wire logic [1:0] step_in,
  output logic a_out,
  output logic b_out
);
  logic [1:0] ph_r = 2'h0;
  // Gray order
  assign a_out = ph_r[1];
  assign b_out = ^ph_r;
  always @(posedge clk_in) begin
    if (move_in) begin
      ph_r <= ph_r + step_in;
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
/* Self-checking bench for the up/down encoder timer.
   Encoder stand-in on the count pins; port checker bound. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_in = 1'h0, rstn = 1'h0, en = 1'h0, md = 1'h0, iv = 1'h1, sch = 1'h0;
  logic rel = 1'h0, mv = 1'h0, ct = 1'h0, xc = 1'h0, qa, qb, cd, cmi, ci0, ci1, oi, ui, top;
  logic [1:0] cs = 2'h0, ec = 2'h1, st = 2'h1;
  logic [2:0] pm = 3'h4, ps = 3'h0;
  logic [15:0] cc = 16'h0005, sc = 16'hfffe, cnt, ch0, ch1;
  logic [31:0] lf = 32'hf828;
  int failures = 0, samples_checked = 0, m = 0, ld = 1, n, nov = 0, nud = 0;
  int eov = 0, eud = 0, ncap = 0, ecap = 0;
  udt_timer i_dut (.clk_in(clk_in), .resetn_in(rstn), .count_enable_bit_in(en),
    .updown_mode_select_in(md), .interval_select_in(iv), .clear_scheme_select_in(sch),
    .clear_source_in(cs), .reload_enable_in(rel), .phase_mode_field_in(pm),
    .prescale_select_in(ps), .output_level_select_in(1'h1), .capcmp_mode_in(2'h0),
    .edge_select_a_in(ec), .edge_select_b_in(ec), .edge_select_cap0_in(ec),
    .edge_select_cap1_in(ec), .cycle_compare_in(cc), .second_compare_in(sc),
    .capcmp_write_0_in(16'h0000), .capcmp_write_1_in(16'h0000), .count_input_a_in(qa),
    .count_input_b_in(qb), .external_clear_pin_in(xc), .capture_trigger_0_in(ct),
    .capture_trigger_1_in(ct), .encoder_counter_out(cnt), .capcmp_channel_0_out(ch0),
    .capcmp_channel_1_out(ch1), .overflow_flag_out(), .count_down_out(cd),
    .timer_out_pin_out(top), .timer_out_pin_oe_out(), .cycle_match_irq_out(cmi),
    .second_match_irq_out(), .capcmp_irq_0_out(ci0), .capcmp_irq_1_out(ci1),
    .overflow_irq_out(oi), .underflow_irq_out(ui));
  udt_enc_model i_enc (.clk_in(clk_in), .move_in(mv), .step_in(st), .a_out(qa), .b_out(qb));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    nov += (oi === 1'h1);
    nud += (ui === 1'h1);
    ncap += (ci0 === 1'h1) + (ci1 === 1'h1);
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int dlt(logic oa, logic ob, logic na, logic nb);
    logic ea = oa ^ na;
    logic eb = ob ^ nb;
    logic ra = na & ea;
    case (pm)
      3'h4: return ra ? (nb ? -1 : 1) : 0;
      3'h5: return ra - (nb & eb);
      3'h6: return ra ? (nb ? 1 : -1) : 0;
      default: return ea & eb ? ld : ea ? (na == nb ? -1 : 1) : eb ? (na != nb ? -1 : 1) : 0;
    endcase
  endfunction
  function automatic int nxt(int c, int d);
    if (sch && c == (d > 0 ? cc : sc)) return 0;
    if (!sch && rel && d < 0 && c == 0) return cc;
    if (!sch && cs[1] && d > 0 && c == cc) return 0;
    return (c + d) & 16'hffff;
  endfunction
  task tally_and_finish;
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(logic [15:0] g, int e);
    samples_checked++;
    if (g !== e[15:0]) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e[15:0]);
    end
  endtask
  task wcm(output int k);
    k = 0;
    do begin
      @(negedge clk_in) k++;
    end while (cmi !== 1'h1 && k < 9000);
    if (k >= 9000) begin
      failures++;
      $display("wrong value at %0t: no match", $time);
      tally_and_finish;
    end
  endtask
  task automatic step(logic [1:0] s);
    logic oa = qa;
    logic ob = qb;
    int d;
    st = s;
    mv = 1'h1;
    @(negedge clk_in) mv = 1'h0;
    d = dlt(oa, ob, qa, qb);
    eov += d > 0 && m == 16'hffff;
    eud += d < 0 && m == 0;
    if (d != 0) begin
      m = nxt(m, d);
      ld = d;
    end
    repeat (8) @(negedge clk_in);
    chk(cnt, m);
    chk(cd, ld < 0);
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk_in);
    rstn = 1'h1;
    for (int s = 0; s < 3; s++) begin
      ps = s[2:0];
      en = 1'h1;
      wcm(n);
      chk(top, 1);
      wcm(n);
      chk(n, (cc + 1) << (3 + s));
      chk(top, 0);
      en = 1'h0;
      @(negedge clk_in);
    end
    rstn = 1'h0;
    md = 1'h1;
    iv = 1'h0;
    @(negedge clk_in) rstn = 1'h1;
    for (int c = 0; c < 3; c++) begin
      {sch, rel, cs} = c == 0 ? 4'h0 : c == 1 ? 4'h8 : 4'h6;
      for (int p = 4; p < 8; p++) begin
        pm = p[2:0];
        en = 1'h1;
        repeat (20) begin
          lf = lfsr(lf);
          step(lf[1:0] == 2'h2 ? 2'h2 : {!lf[0], 1'h1});
        end
        en = 1'h0;
      end
    end
    chk(nov, eov);
    chk(nud, eud);
    en = 1'h1;
    for (int e = 1; e < 4; e++) begin
      ec = e[1:0];
      step(2'h1);
      ecap += e == 3 ? 4 : 2;
      ct = 1'h1;
      repeat (8) @(negedge clk_in);
      ct = 1'h0;
      repeat (8) @(negedge clk_in);
      chk(ch0, m);
      chk(ch1, m);
    end
    cs = 2'h1;
    step(2'h1);
    xc = 1'h1;
    repeat (8) @(negedge clk_in);
    xc = 1'h0;
    m = 0;
    chk(cnt, m);
    chk(ncap, ecap);
    tally_and_finish;
  end
endmodule
`default_nettype wire
